// File: hdl/clkgen_pkg.sv
// Shared constants and types of the CPU clock generator
package clkgen_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned MAIN_PERIOD_NS    = 200;
  localparam int unsigned MAIN_DIV          = MAIN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned MIN_INSTR_FAST_NS = 400;
  localparam int unsigned MIN_INSTR_SLOW_NS = 1600;
  localparam int unsigned MIN_INSTR_SUB_NS  = 122000;
  localparam int unsigned SLOW_DIV          = MIN_INSTR_SLOW_NS / MIN_INSTR_FAST_NS;
  localparam int unsigned SUB_DIV           = 2;
  localparam int unsigned STAB_EXP          = 15;
  localparam int unsigned STAB_TICKS        = 2 ** STAB_EXP;

  // ----------------------------------------------------------------
  // Register layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PROC_CTRL_RESET = 8'h02;
  localparam logic [7:0] SUB_MODE_RESET  = 8'h00;
  localparam logic [7:0] SUB_CTRL_RESET  = 8'h00;
  localparam int unsigned MAIN_STOP_BIT   = 7;
  localparam int unsigned SPEED_BIT       = 1;
  localparam int unsigned SUB_STOP_BIT    = 0;
  localparam int unsigned FB_OFF_BIT      = 1;
  localparam int unsigned SRC_SEL_BIT     = 4;
  localparam int unsigned ON_SUB_BIT      = 5;

  // ----------------------------------------------------------------
  // Switching latency in CPU clocks of the old source
  // ----------------------------------------------------------------
  localparam int unsigned LAT_W = 9;
  localparam logic [LAT_W-1:0] LAT_FAST_TO_SLOW = 9'h004;
  localparam logic [LAT_W-1:0] LAT_TO_FAST      = 9'h002;
  localparam logic [LAT_W-1:0] LAT_SUB_TO_SLOW  = 9'h002;
  localparam logic [LAT_W-1:0] LAT_SLOW_TO_SUB  = 9'h132;
  localparam logic [LAT_W-1:0] LAT_FAST_TO_SUB  = 9'h04C;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_FAST = 2'h0,
    SRC_SLOW = 2'h1,
    SRC_SUB  = 2'h2
  } cpu_src_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_HALT = 2'h1,
    ST_STOP = 2'h3
  } standby_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } reg_wr_t;

endpackage

// File: hdl/cpu_clock_gen.sv
// CPU clock generator control: source select, oscillator control, standby
//
// Operation
// RULE_01 - Reset selects slow main clock, control 02H
// RULE_02 - Main oscillator stopped while reset held
// RULE_03 - Offer 0.4us, 1.6us and 122us instruction times
// RULE_04 - STOP and HALT allowed on main clock
// RULE_05 - Feedback resistor bit disconnects sub resistor
// RULE_06 - Sub stop bit halts subsystem oscillator
// RULE_07 - Oscillator select bit picks subsystem clock
// RULE_08 - Main stop bit halts main oscillator on sub
// RULE_09 - On subsystem clock HALT allowed, STOP refused
// RULE_10 - Peripherals from main; sub feeds watch/LCD only
// RULE_11 - Watch and LCD clock runs during standby
// RULE_12 - Other peripherals stop with main clock
// RULE_13 - Speed and select bits jointly pick source
// RULE_14 - Switch applies after table latency in clocks
// RULE_15 - Latency counted in clocks of old source
// RULE_16 - Reset release waits 2^15 main periods
// RULE_17 - Software selects sub only when it is stable
// RULE_18 - Software restarts main and waits before return
// RULE_19 - Main stop write ignored unless on sub
// RULE_20 - Encoding 00 main, 01 main/4, 1x sub/2
// RULE_21 - Status bit 5 shows CPU running on sub
// RULE_22 - Source changes without runt clock pulses
module cpu_clock_gen #(
  parameter int unsigned STAB_TICKS = clkgen_pkg::STAB_TICKS
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Software register writes
  input  clkgen_pkg::reg_wr_t proc_ctrl_wr_i,
  input  clkgen_pkg::reg_wr_t sub_mode_wr_i,
  input  clkgen_pkg::reg_wr_t sub_ctrl_wr_i,
  // Standby control from the CPU
  input  wire logic          halt_req_i,
  input  wire logic          stop_req_i,
  input  wire logic          wake_i,
  // Subsystem oscillator pin
  input  wire logic          sub_osc_pin_i,
  // Register read values
  output logic [7:0]         processor_clock_ctrl_o,
  output logic [7:0]         suboscillator_mode_reg_o,
  output logic [7:0]         subclock_ctrl_reg_o,
  // Oscillator control
  output logic               main_osc_en_o,
  output logic               sub_osc_en_o,
  output logic               feedback_resistor_off_o,
  // Clock enables
  output logic               cpu_clk_en_o,
  output logic               periph_clk_en_o,
  output logic               sub_periph_clk_en_o,
  // Standby status
  output logic               halt_o,
  output logic               stop_o
);

  localparam int unsigned SW = $clog2(STAB_TICKS) + 1;
  localparam logic [SW-1:0] STAB_LAST = SW'(STAB_TICKS - 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 main_osc_stop_q;
  logic                 cpu_speed_select_q;
  logic                 sub_osc_stop_q;
  logic                 feedback_resistor_off_q;
  logic                 osc_source_select_q;
  clkgen_pkg::cpu_src_t sel_q;
  clkgen_pkg::cpu_src_t tgt_q;
  clkgen_pkg::cpu_src_t req_src;
  logic                 pend_q;
  logic [clkgen_pkg::LAT_W-1:0] lat_q;
  clkgen_pkg::standby_t mode_q;
  logic [SW-1:0]        stab_cnt_q;
  logic                 stable_q;
  logic                 sub_s;
  logic                 sub_prev_q;
  logic                 sub_edge;
  logic                 main_tick;
  logic                 slow_tick;
  logic                 sub_cpu_tick;
  logic                 src_tick;
  logic                 apply;
  logic                 on_sub;

  // ----------------------------------------------------------------
  // Latency lookup
  // ----------------------------------------------------------------
  function automatic logic [clkgen_pkg::LAT_W-1:0] lat_f(
    input clkgen_pkg::cpu_src_t from,
    input clkgen_pkg::cpu_src_t to
  );
    lat_f = clkgen_pkg::LAT_TO_FAST;
    case (to)
      clkgen_pkg::SRC_SLOW: begin
        lat_f = (from == clkgen_pkg::SRC_SUB) ? clkgen_pkg::LAT_SUB_TO_SLOW
                                              : clkgen_pkg::LAT_FAST_TO_SLOW;
      end
      clkgen_pkg::SRC_SUB: begin
        lat_f = (from == clkgen_pkg::SRC_SLOW) ? clkgen_pkg::LAT_SLOW_TO_SUB
                                               : clkgen_pkg::LAT_FAST_TO_SUB;
      end
      default: lat_f = clkgen_pkg::LAT_TO_FAST;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  assign on_sub = (sel_q == clkgen_pkg::SRC_SUB);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_osc_stop_q    <= clkgen_pkg::PROC_CTRL_RESET[clkgen_pkg::MAIN_STOP_BIT];
      cpu_speed_select_q <= clkgen_pkg::PROC_CTRL_RESET[clkgen_pkg::SPEED_BIT]; // see RULE_01
    end else if (proc_ctrl_wr_i.wr) begin
      cpu_speed_select_q <= proc_ctrl_wr_i.data[clkgen_pkg::SPEED_BIT];
      if (!proc_ctrl_wr_i.data[clkgen_pkg::MAIN_STOP_BIT]) begin
        main_osc_stop_q <= 1'b0;
      end else if (on_sub) begin
        main_osc_stop_q <= 1'b1; // see RULE_08 see RULE_19
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sub_osc_stop_q          <= clkgen_pkg::SUB_MODE_RESET[clkgen_pkg::SUB_STOP_BIT];
      feedback_resistor_off_q <= clkgen_pkg::SUB_MODE_RESET[clkgen_pkg::FB_OFF_BIT];
    end else if (sub_mode_wr_i.wr) begin
      sub_osc_stop_q          <= sub_mode_wr_i.data[clkgen_pkg::SUB_STOP_BIT];
      feedback_resistor_off_q <= sub_mode_wr_i.data[clkgen_pkg::FB_OFF_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_source_select_q <= clkgen_pkg::SUB_CTRL_RESET[clkgen_pkg::SRC_SEL_BIT];
    end else if (sub_ctrl_wr_i.wr) begin
      osc_source_select_q <= sub_ctrl_wr_i.data[clkgen_pkg::SRC_SEL_BIT]; // see RULE_07
    end
  end

  // ----------------------------------------------------------------
  // Oscillators and dividers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_osc_en_o           <= 1'b0; // see RULE_02
      sub_osc_en_o            <= 1'b0;
      feedback_resistor_off_o <= 1'b0;
    end else begin
      main_osc_en_o           <= !main_osc_stop_q && (mode_q != clkgen_pkg::ST_STOP);
      sub_osc_en_o            <= !sub_osc_stop_q; // see RULE_06
      feedback_resistor_off_o <= feedback_resistor_off_q; // see RULE_05
    end
  end

  // Main oscillator period as an enable
  tick_divider #(.DIV(clkgen_pkg::MAIN_DIV)) u_main_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (!main_osc_en_o),
    .en_i   (main_osc_en_o),
    .tick_o (main_tick)
  );

  // Slow main CPU clock main/4, restarted on a switch
  tick_divider #(.DIV(clkgen_pkg::SLOW_DIV)) u_slow_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (apply),
    .en_i   (main_tick),
    .tick_o (slow_tick)
  );

  sync2 u_sub_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sub_osc_pin_i),
    .q_o   (sub_s)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sub_prev_q <= 1'b0;
    end else begin
      sub_prev_q <= sub_s;
    end
  end

  assign sub_edge = sub_s && !sub_prev_q && sub_osc_en_o;

  // Subsystem CPU clock sub/2, restarted on a switch
  tick_divider #(.DIV(clkgen_pkg::SUB_DIV)) u_sub_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (apply),
    .en_i   (sub_edge),
    .tick_o (sub_cpu_tick)
  );

  // ----------------------------------------------------------------
  // Source selection and switching
  // ----------------------------------------------------------------
  always_comb begin
    if (osc_source_select_q) begin
      req_src = clkgen_pkg::SRC_SUB; // see RULE_13 see RULE_20
    end else if (cpu_speed_select_q) begin
      req_src = clkgen_pkg::SRC_SLOW;
    end else begin
      req_src = clkgen_pkg::SRC_FAST;
    end
  end

  always_comb begin
    case (sel_q)
      clkgen_pkg::SRC_FAST: src_tick = main_tick; // see RULE_03
      clkgen_pkg::SRC_SLOW: src_tick = slow_tick;
      clkgen_pkg::SRC_SUB:  src_tick = sub_cpu_tick;
      default:              src_tick = 1'b0;
    endcase
  end

  // Switch only on an old-source edge, then restart the slow and sub dividers
  assign apply = pend_q && src_tick && (lat_q == clkgen_pkg::LAT_W'(1)); // see RULE_22

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_q  <= clkgen_pkg::SRC_SLOW; // see RULE_01
      tgt_q  <= clkgen_pkg::SRC_SLOW;
      pend_q <= 1'b0;
      lat_q  <= '0;
    end else if (req_src != tgt_q) begin
      tgt_q  <= req_src;
      pend_q <= (req_src != sel_q);
      lat_q  <= lat_f(sel_q, req_src); // see RULE_14
    end else if (pend_q && src_tick) begin
      lat_q <= lat_q - clkgen_pkg::LAT_W'(1); // see RULE_15
      if (apply) begin
        sel_q  <= tgt_q;
        pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stabilization wait
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stab_cnt_q <= '0;
      stable_q   <= 1'b0;
    end else if (mode_q == clkgen_pkg::ST_STOP) begin
      stab_cnt_q <= '0;
      stable_q   <= 1'b0;
    end else if (!stable_q && main_tick) begin
      stab_cnt_q <= stab_cnt_q + SW'(1);
      stable_q   <= (stab_cnt_q == STAB_LAST); // see RULE_16
    end
  end

  // ----------------------------------------------------------------
  // Standby modes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= clkgen_pkg::ST_RUN;
    end else begin
      case (mode_q)
        clkgen_pkg::ST_RUN: begin
          if (stop_req_i && !on_sub) begin
            mode_q <= clkgen_pkg::ST_STOP; // see RULE_04 see RULE_09
          end else if (halt_req_i) begin
            mode_q <= clkgen_pkg::ST_HALT;
          end
        end
        clkgen_pkg::ST_HALT: begin
          if (wake_i) begin
            mode_q <= clkgen_pkg::ST_RUN;
          end
        end
        clkgen_pkg::ST_STOP: begin
          if (wake_i) begin
            mode_q <= clkgen_pkg::ST_RUN;
          end
        end
        default: mode_q <= clkgen_pkg::ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_clk_en_o        <= 1'b0;
      periph_clk_en_o     <= 1'b0;
      sub_periph_clk_en_o <= 1'b0;
      halt_o              <= 1'b0;
      stop_o              <= 1'b0;
    end else begin
      cpu_clk_en_o        <= src_tick && (stable_q || on_sub) && (mode_q == clkgen_pkg::ST_RUN);
      periph_clk_en_o     <= main_tick; // see RULE_10 see RULE_12
      sub_periph_clk_en_o <= sub_edge; // see RULE_11
      halt_o              <= (mode_q == clkgen_pkg::ST_HALT);
      stop_o              <= (mode_q == clkgen_pkg::ST_STOP);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      processor_clock_ctrl_o   <= clkgen_pkg::PROC_CTRL_RESET;
      suboscillator_mode_reg_o <= clkgen_pkg::SUB_MODE_RESET;
      subclock_ctrl_reg_o      <= clkgen_pkg::SUB_CTRL_RESET;
    end else begin
      processor_clock_ctrl_o   <= {main_osc_stop_q, 5'h00, cpu_speed_select_q, 1'b0};
      suboscillator_mode_reg_o <= {6'h00, feedback_resistor_off_q, sub_osc_stop_q};
      subclock_ctrl_reg_o      <= {2'h0, on_sub, osc_source_select_q, 4'h0}; // see RULE_21
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reset_ctrl_value: assert property ( // see RULE_01
    @(posedge clk_i) $past(rst_i) |-> processor_clock_ctrl_o == 8'h02
  ) else $error("control register not 02H after reset");

  chk_main_osc_reset: assert property ( // see RULE_02
    @(posedge clk_i) rst_i |-> !main_osc_en_o
  ) else $error("main oscillator running in reset");

  chk_stop_refused_sub: assert property ( // see RULE_09
    @(posedge clk_i) disable iff (rst_i)
    (mode_q == clkgen_pkg::ST_RUN && on_sub) |=> mode_q != clkgen_pkg::ST_STOP
  ) else $error("STOP entered on subsystem clock");

  chk_main_stop_ignored: assert property ( // see RULE_19
    @(posedge clk_i) disable iff (rst_i)
    (!on_sub && !main_osc_stop_q) |=> !main_osc_stop_q
  ) else $error("main stop bit set while on main clock");

  chk_sub_osc_stop: assert property ( // see RULE_06
    @(posedge clk_i) disable iff (rst_i)
    sub_osc_stop_q [*3] |-> !sub_osc_en_o && !sub_periph_clk_en_o
  ) else $error("subsystem oscillator not stopped");

  chk_cpu_after_stab: assert property ( // see RULE_16
    @(posedge clk_i) disable iff (rst_i)
    $rose(cpu_clk_en_o) && !$past(on_sub) |-> $past(stable_q)
  ) else $error("CPU clock before stabilization");

  chk_halt_gates_cpu: assert property ( // see RULE_04
    @(posedge clk_i) disable iff (rst_i)
    halt_o |-> !cpu_clk_en_o
  ) else $error("CPU clock running in HALT");

  chk_switch_on_edge: assert property ( // see RULE_22
    @(posedge clk_i) disable iff (rst_i)
    $changed(sel_q) |-> $past(src_tick && pend_q && lat_q == 9'h001)
  ) else $error("source changed off an old-clock edge");

  chk_latency_load: assert property ( // see RULE_14
    @(posedge clk_i) disable iff (rst_i)
    (req_src == clkgen_pkg::SRC_SUB && tgt_q != req_src && sel_q == clkgen_pkg::SRC_SLOW)
      |=> lat_q == 9'h132 && pend_q
  ) else $error("slow-to-sub latency not 306");

  chk_fast_sub_latency: assert property ( // see RULE_14
    @(posedge clk_i) disable iff (rst_i)
    (req_src == clkgen_pkg::SRC_SUB && tgt_q != req_src && sel_q == clkgen_pkg::SRC_FAST)
      |=> lat_q == 9'h04C && pend_q
  ) else $error("fast-to-sub latency not 76");

  chk_on_sub_status: assert property ( // see RULE_21
    @(posedge clk_i) disable iff (rst_i)
    ##1 subclock_ctrl_reg_o[5] == $past(on_sub)
  ) else $error("status bit does not follow CPU source");

endmodule

// File: hdl/sync2.sv
// Two-flop synchroniser for a level from outside the clock domain
module sync2 (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Level
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

// File: hdl/tick_divider.sv
// Enable-pulse divider: one output pulse per DIV input pulses
module tick_divider #(
  parameter int unsigned DIV = 4
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic clr_i,
  input  wire logic en_i,
  // Divided pulse
  output logic      tick_o
);

  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (clr_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (en_i) begin
        if (cnt_q == LAST) begin
          cnt_q  <= '0;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + W'(1);
        end
      end
    end
  end

endmodule

// File: verif/sub_osc_model.sv
// Behavioural subsystem crystal oscillator driving the clock generator pin
module sub_osc_model #(
  parameter int unsigned HALF_NS = 500
) (
  // Oscillator control
  input  wire logic en_i,
  // Oscillator output
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Square wave, held low while disabled
  // ----------------------------------------------------------------
  initial begin
    pin_o = 1'b0;
    #13;
    forever begin
      #(HALF_NS);
      if (en_i === 1'b1) begin
        pin_o = ~pin_o;
      end else begin
        pin_o = 1'b0;
      end
    end
  end
endmodule

// File: verif/tb_cpu_clock_gen.sv
// Self-checking testbench of the CPU clock generator control
module tb_cpu_clock_gen;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  clkgen_pkg::reg_wr_t proc_ctrl_wr_i = '0;
  clkgen_pkg::reg_wr_t sub_mode_wr_i = '0;
  clkgen_pkg::reg_wr_t sub_ctrl_wr_i = '0;
  logic                halt_req_i = 1'b0;
  logic                stop_req_i = 1'b0;
  logic                wake_i = 1'b0;
  logic                sub_osc_pin_i;
  logic [7:0]          proc_ctrl, sub_mode, sub_ctrl;
  logic                main_en, sub_en, fb_off, cpu_en, per_en, sub_per_en, halt_o, stop_o;
  int                  err_count = 0;
  int                  n_tests = 0;
  int                  meas, n, g;
  logic [7:0]          d;
  logic [7:0]          exp_q[$];
  int                  sel_q[$];
  event                obs_ev;

  always #25 clk_i = ~clk_i;

  cpu_clock_gen #(.STAB_TICKS(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .proc_ctrl_wr_i(proc_ctrl_wr_i),
    .sub_mode_wr_i(sub_mode_wr_i), .sub_ctrl_wr_i(sub_ctrl_wr_i),
    .halt_req_i(halt_req_i), .stop_req_i(stop_req_i),
    .wake_i(wake_i), .sub_osc_pin_i(sub_osc_pin_i), .processor_clock_ctrl_o(proc_ctrl),
    .suboscillator_mode_reg_o(sub_mode), .subclock_ctrl_reg_o(sub_ctrl),
    .main_osc_en_o(main_en), .sub_osc_en_o(sub_en), .feedback_resistor_off_o(fb_off),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .sub_periph_clk_en_o(sub_per_en),
    .halt_o(halt_o), .stop_o(stop_o));

  sub_osc_model #(.HALF_NS(500)) osc (.en_i(sub_en), .pin_o(sub_osc_pin_i));

  // ----------------------------------------------------------------
  // Observation and scoreboard
  // ----------------------------------------------------------------
  function automatic logic [7:0] obs(int sel);
    case (sel)
      0: return proc_ctrl;
      1: return sub_mode;
      2: return sub_ctrl;
      3: return {main_en, sub_en, fb_off, halt_o, stop_o, 3'h0};
      default: return meas[7:0];
    endcase
  endfunction

  function automatic logic hit(int which);
    case (which)
      0: return cpu_en === 1'b1;
      1: return per_en === 1'b1;
      2: return sub_per_en === 1'b1;
      3: return sub_ctrl[5] === 1'b1;
      default: return sub_ctrl[5] === 1'b0;
    endcase
  endfunction

  task automatic note(int sel, logic [7:0] e);
    exp_q.push_back(e);
    sel_q.push_back(sel);
    ->obs_ev;
    #1;
  endtask

  initial begin
    int s;
    logic [7:0] e;
    forever begin
      @(obs_ev);
      s = sel_q.pop_front();
      e = exp_q.pop_front();
      n_tests++;
      if (obs(s) !== e) begin
        err_count++;
        $display("CHECK FAILED at %0t: output %0d is %h, expected %h", $time, s, obs(s), e);
      end
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic wr(int r, logic [7:0] v);
    @(posedge clk_i);
    #1;
    case (r)
      0: proc_ctrl_wr_i = '{wr: 1'b1, data: v};
      1: sub_mode_wr_i = '{wr: 1'b1, data: v};
      default: sub_ctrl_wr_i = '{wr: 1'b1, data: v};
    endcase
    @(posedge clk_i);
    #1;
    proc_ctrl_wr_i = '0;
    sub_mode_wr_i = '0;
    sub_ctrl_wr_i = '0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(int k);
    @(posedge clk_i);
    #1;
    halt_req_i = (k == 0);
    stop_req_i = (k == 1);
    wake_i = (k == 2);
    @(posedge clk_i);
    #1;
    {halt_req_i, stop_req_i, wake_i} = 3'h0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic wait_en(int which, int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_i);
      #1;
      cnt++;
    end while (!hit(which) && cnt < lim);
    if (!hit(which)) begin
      err_count++;
      $display("CHECK FAILED at %0t: wait %0d timed out", $time, which);
      end_of_test();
    end
  endtask

  task automatic gap(int which, output int cnt);
    int x;
    wait_en(which, 5000, x);
    wait_en(which, 5000, cnt);
  endtask

  task automatic count(int which, int cycles, output int c);
    c = 0;
    repeat (cycles) begin
      @(posedge clk_i);
      #1;
      if (hit(which)) c++;
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(75));
    repeat (4) @(posedge clk_i);
    #1;
    note(0, 8'h02);
    note(1, 8'h00);
    note(2, 8'h00);
    note(3, 8'h00);
    rst_i = 1'b0;
    wait_en(0, 2000, n);
    meas = (n >= 32 && n <= 64);
    note(4, 8'h01);
    gap(0, g);
    meas = g;
    note(4, 8'h10);
    gap(1, g);
    meas = g;
    note(4, 8'h04);
    note(3, 8'hC0);
    $display("Test reset and start-up done");

    d = 8'($urandom()) & 8'h7C;
    wr(0, 8'h82 | d);
    note(0, 8'h02);
    wr(1, 8'h03 | d);
    note(1, 8'h03);
    note(3, 8'hA0);
    wr(1, 8'h00);
    note(3, 8'hC0);
    $display("Test register writes done");

    wr(0, d);
    note(0, 8'h00);
    repeat (40) @(posedge clk_i);
    gap(0, g);
    meas = g;
    note(4, 8'h04);
    $display("Test fast main clock done");

    wr(2, 8'h10 | (8'($urandom()) & 8'h0F));
    note(2, 8'h10);
    wait_en(3, 2000, n);
    meas = (n >= 280 && n <= 400);
    note(4, 8'h01);
    note(2, 8'h30);
    gap(0, g);
    meas = g;
    note(4, 8'h28);
    $display("Test switch to subsystem done");

    pulse(1);
    note(3, 8'hC0);
    pulse(0);
    note(3, 8'hD0);
    count(0, 200, meas);
    note(4, 8'h00);
    count(2, 200, meas);
    meas = (meas > 0);
    note(4, 8'h01);
    pulse(2);
    note(3, 8'hC0);
    $display("Test standby on subsystem done");

    wr(0, 8'h80);
    note(0, 8'h80);
    note(3, 8'h40);
    count(1, 100, meas);
    note(4, 8'h00);
    wr(0, 8'h00);
    repeat (60) @(posedge clk_i);
    wr(2, 8'h00);
    wait_en(4, 2000, n);
    note(2, 8'h00);
    pulse(1);
    note(3, 8'h48);
    pulse(2);
    wait_en(0, 2000, n);
    note(3, 8'hC0);
    $display("Test main stop and return done");

    wr(0, 8'h02);
    note(0, 8'h02);
    repeat (40) @(posedge clk_i);
    gap(0, g);
    meas = g;
    note(4, 8'h10);
    wr(2, 8'h10);
    wait_en(3, 6000, n);
    meas = (n >= 4800 && n <= 5000);
    note(4, 8'h01);
    $display("Test slow main to subsystem done");
    end_of_test();
  end
endmodule
